// *** inc/uls_pkg.sv ***
// Functional notes
// RQ1 - error summary set while FIFO holds tagged char
// RQ2 - reading line flags clears error summary
// RQ3 - non-FIFO: transmit empty when holding and shifter empty
// RQ4 - transmit empty drops once a character waits
// RQ5 - FIFO mode: transmit empty needs FIFO and shifter empty
// RQ6 - non-FIFO: holding empty set on move to shifter
// RQ7 - holding empty cleared on CPU transmit write
// RQ8 - interrupt while holding empty and enabled
// RQ9 - FIFO mode: holding empty set when FIFO empties
// RQ10 - FIFO mode: holding empty cleared on byte written
// RQ11 - break flag after line low one frame
// RQ12 - one break character stored per break
// RQ13 - error, break, framing flags default to zero
// RQ14 - framing error follows top character
// RQ15 - parity error follows top character
// RQ16 - overrun on full FIFO, contents kept intact
// RQ17 - data ready while receive side holds characters
// RQ18 - flag reads leave transmit flags untouched
package uls_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] OFS_TX_DATA    = 4'h0;
  localparam logic [3:0] OFS_LINE_FLAGS = 4'h1;
  localparam logic [3:0] OFS_CONTROL    = 4'h2;
  localparam logic [3:0] OFS_EVT_STATUS = 4'h3;
  localparam logic [3:0] OFS_EVT_MASK   = 4'h4;
  // line_condition_flags bit positions
  localparam int LF_DATA_READY = 0;
  localparam int LF_OVERRUN    = 1;
  localparam int LF_PARITY     = 2;
  localparam int LF_FRAMING    = 3;
  localparam int LF_BREAK      = 4;
  localparam int LF_HOLD_EMPTY = 5;
  localparam int LF_TX_EMPTY   = 6;
  localparam int LF_ERR_SUM    = 7;
  // control register fields and reset
  localparam int         CTL_FIFO_EN  = 0;
  localparam int         CTL_HOLD_IE  = 1;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  // event status / mask layout
  localparam int         EVT_HOLD     = 0;
  localparam int         EVT_BREAK    = 1;
  localparam int         EVT_OVERRUN  = 2;
  localparam int         EVT_RX_ERR   = 3;
  localparam int         EVT_W        = 4;
  localparam logic [3:0] EVT_RESET    = 4'h0;
  // per-character receive tags
  localparam int         TAG_PE       = 0;
  localparam int         TAG_FE       = 1;
  localparam int         TAG_BRK      = 2;
  localparam int         TAG_W        = 3;
  // transmit flags come out of reset empty
  localparam logic       HOLD_EMPTY_RESET = 1'b1;
  localparam logic       TX_EMPTY_RESET   = 1'b1;
  // receive FIFO depth in characters
  localparam int         RX_DEPTH     = 32;
  // break detector states, gray along idle-count-held
  typedef enum logic [1:0] {
    BRK_IDLE  = 2'b00,
    BRK_COUNT = 2'b01,
    BRK_HELD  = 2'b11
  } uls_brk_state_t;
endpackage : uls_pkg

// *** inc/uls_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// link between the core, the receive tag store and the break detector
interface uls_if #(parameter int CW = 6);
  logic                       push;       // store one character's tags
  logic [uls_pkg::TAG_W-1:0]  push_tags;  // tags of that character
  logic                       pop;        // oldest character leaves
  logic [uls_pkg::TAG_W-1:0]  top_tags;   // tags of oldest character
  logic [CW-1:0]              count;      // characters held
  logic                       err_any;    // some held char is tagged
  logic                       brk_event;  // one pulse per break
  logic                       brk_active; // line still held in break
  modport tag_store (input push, push_tags, pop, output top_tags, count, err_any);
  modport brk_det   (output brk_event, brk_active);
  modport core      (output push, push_tags, pop,
                     input  top_tags, count, err_any, brk_event, brk_active);
endinterface : uls_if
`default_nettype wire

// *** hdl/uls_rx_tags.sv ***
`timescale 1ns/1ps
`default_nettype none
// error tags shadowing the receive FIFO, one entry per character
module uls_rx_tags #(
  parameter int DEPTH = uls_pkg::RX_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // link to the core
  uls_if.tag_store  tif
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [uls_pkg::TAG_W-1:0] tags_r [DEPTH]; // tag storage
  logic [AW-1:0]             wr_ptr_r;       // next free entry
  logic [AW-1:0]             rd_ptr_r;       // oldest entry
  logic [CW-1:0]             cnt_r;          // entries held
  logic [CW-1:0]             err_cnt_r;      // entries with any tag

  // wrap pointer at depth, not at a power of two
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : ptr_inc

  // storage write, core never pushes when full
  always_ff @(posedge clk) begin
    if (tif.push) begin
      tags_r[wr_ptr_r] <= tif.push_tags;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      if (tif.push) wr_ptr_r <= ptr_inc(wr_ptr_r);
      if (tif.pop) rd_ptr_r <= ptr_inc(rd_ptr_r);
      cnt_r <= cnt_r + CW'(tif.push) - CW'(tif.pop);
    end
  end

  // count of tagged entries still held
  always_ff @(posedge clk) begin
    if (rst) begin
      err_cnt_r <= '0;
    end else begin
      err_cnt_r <= err_cnt_r + CW'(tif.push && |tif.push_tags)
                             - CW'(tif.pop && |tags_r[rd_ptr_r]);
    end
  end

  assign tif.top_tags = (cnt_r != '0) ? tags_r[rd_ptr_r] : '0; // RQ14 RQ15
  assign tif.count    = cnt_r;
  assign tif.err_any  = (err_cnt_r != '0); // RQ1
endmodule : uls_rx_tags
`default_nettype wire

// *** hdl/uls_break_det.sv ***
`timescale 1ns/1ps
`default_nettype none
// break detector: line low for a whole frame, one event per break
module uls_break_det (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // receive line counted once per bit time, checked for high on every clock
  input  wire logic       rx_serial_in,
  input  wire logic       rx_bit_tick,
  input  wire logic [3:0] frame_bits,
  // link to the core
  uls_if.brk_det          bif
);
  uls_pkg::uls_brk_state_t state_r;    // detector state
  logic [3:0]              low_cnt_r;  // bit times seen low
  logic                    event_r;    // break event pulse

  // count low bit times; held state waits for the line to rise
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= uls_pkg::BRK_IDLE;
      low_cnt_r <= 4'h0;
      event_r   <= 1'b0;
    end else begin
      event_r <= 1'b0;
      unique case (state_r)
        uls_pkg::BRK_IDLE: begin
          if (rx_bit_tick && !rx_serial_in) begin
            low_cnt_r <= 4'h1;
            if (frame_bits <= 4'h1) begin
              state_r <= uls_pkg::BRK_HELD;
              event_r <= 1'b1; // RQ11
            end else begin
              state_r <= uls_pkg::BRK_COUNT;
            end
          end
        end
        uls_pkg::BRK_COUNT: begin
          if (rx_serial_in) begin
            state_r <= uls_pkg::BRK_IDLE; // a high bit ends the run
          end else if (rx_bit_tick) begin
            low_cnt_r <= low_cnt_r + 4'h1;
            if (low_cnt_r + 4'h1 >= frame_bits) begin
              state_r <= uls_pkg::BRK_HELD;
              event_r <= 1'b1; // RQ11
            end
          end
        end
        uls_pkg::BRK_HELD: begin
          if (rx_serial_in) state_r <= uls_pkg::BRK_IDLE; // RQ12
        end
        default: state_r <= uls_pkg::BRK_IDLE; // illegal code
      endcase
    end
  end

  assign bif.brk_event  = event_r;
  assign bif.brk_active = (state_r == uls_pkg::BRK_HELD);
endmodule : uls_break_det
`default_nettype wire

// *** hdl/uls_top.sv ***
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
// line status logic: transmit empty states, receive error flags,
// break handling and the interrupt outputs
module uls_top #(
  parameter int RX_DEPTH = uls_pkg::RX_DEPTH
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // transmit path status from the rest of the unit
  input  wire logic       tx_to_shifter,
  input  wire logic       tx_shifter_busy,
  input  wire logic       tx_fifo_empty,
  // transmit load toward the holding stage or FIFO
  output logic            hold_load,
  output logic      [7:0] hold_load_data,
  // receiver character completions
  input  wire logic       rx_char_done,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_framing_err,
  input  wire logic       rx_pop,
  // receive line for break detection
  input  wire logic       rx_serial_in,
  input  wire logic       rx_bit_tick,
  input  wire logic [3:0] frame_bits,
  // receive store control toward the data FIFO
  output logic            rx_store,
  output logic            rx_store_break,
  // interrupts
  output logic            hold_empty_irq,
  output logic            irq
);
  localparam int CW = $clog2(RX_DEPTH + 1);

  // link to the tag store and the break detector
  uls_if #(.CW(CW)) lnk ();

  // decoded register strobes
  logic tx_wr;       // cpu write to the transmit data
  logic ctl_wr;      // cpu write to control
  logic evt_wr;      // write-one-to-clear of events
  logic mask_wr;     // cpu write to the mask
  logic flags_rd;    // cpu read of line_condition_flags

  // control state
  logic [7:0] ctl_r;    // control register
  logic       fifo_en;  // FIFO mode selected
  logic       hold_ie;  // holding-empty interrupt enable

  // transmit state
  logic hold_empty_r;     // holding stage or FIFO empty
  logic hold_empty_nxt;
  logic tx_empty_r;       // whole transmit path empty
  logic tx_empty_nxt;
  logic fifo_empty_d_r;   // last cycle's FIFO empty, for edge
  logic hold_set;         // holding-empty set condition

  // receive state
  logic          rx_full;      // no room for another character
  logic [CW-1:0] rx_cap;       // capacity for the current mode
  logic          char_in;      // completed character to consider
  logic          want_push;    // character or break wants storing
  logic          do_push;      // accepted into the store
  logic [2:0]    new_tags;     // tags of the incoming entry
  logic          overrun_set;  // dropped for lack of room
  logic          overrun_r;    // overrun flag
  logic          err_sum_r;    // receive error summary
  logic          err_push;     // tagged entry stored now
  logic          data_ready;   // store not empty

  // interrupt state
  logic [uls_pkg::EVT_W-1:0] evt_r;     // sticky event bits
  logic [uls_pkg::EVT_W-1:0] evt_nxt;
  logic [uls_pkg::EVT_W-1:0] evt_set;   // events this cycle
  logic [uls_pkg::EVT_W-1:0] mask_r;    // event mask
  logic [uls_pkg::EVT_W-1:0] mask_nxt;

  // read path
  logic [7:0] flags;        // assembled line_condition_flags
  logic [7:0] rdata_nxt;    // next read data
  logic [7:0] rdata_r;      // read data register

  // output flops
  logic       hold_load_r;
  logic [7:0] hold_load_data_r;
  logic       rx_store_r;
  logic       rx_store_break_r;
  logic       hold_empty_irq_r;
  logic       irq_r;

  // address decode; unmapped offsets do nothing
  assign tx_wr    = reg_wr && (reg_addr == uls_pkg::OFS_TX_DATA);
  assign ctl_wr   = reg_wr && (reg_addr == uls_pkg::OFS_CONTROL);
  assign evt_wr   = reg_wr && (reg_addr == uls_pkg::OFS_EVT_STATUS);
  assign mask_wr  = reg_wr && (reg_addr == uls_pkg::OFS_EVT_MASK);
  assign flags_rd = reg_rd && (reg_addr == uls_pkg::OFS_LINE_FLAGS);

  assign fifo_en  = ctl_r[uls_pkg::CTL_FIFO_EN];
  assign hold_ie  = ctl_r[uls_pkg::CTL_HOLD_IE];

  // control register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_r <= uls_pkg::CTL_RESET;
    end else if (ctl_wr) begin
      ctl_r <= reg_wdata;
    end
  end

  // ---- transmit side ----

  // holding-empty set source depends on the mode
  always_comb begin
    if (fifo_en) begin
      hold_set = tx_fifo_empty && !fifo_empty_d_r; // RQ9
    end else begin
      hold_set = tx_to_shifter; // RQ6
    end
  end

  // a load in the same cycle wins: the stage is occupied again
  always_comb begin
    if (tx_wr) begin
      hold_empty_nxt = 1'b0; // RQ7 RQ10
    end else if (hold_set) begin
      hold_empty_nxt = 1'b1;
    end else begin
      hold_empty_nxt = hold_empty_r;
    end
  end

  // transmit empty needs every stage empty, including a char in flight
  always_comb begin
    tx_empty_nxt = hold_empty_nxt && !tx_shifter_busy && !tx_to_shifter; // RQ3 RQ4
    if (fifo_en && !tx_fifo_empty) begin
      tx_empty_nxt = 1'b0; // RQ5
    end
  end

  // transmit flags; flag reads never touch them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_empty_r   <= uls_pkg::HOLD_EMPTY_RESET;
      tx_empty_r     <= uls_pkg::TX_EMPTY_RESET;
      fifo_empty_d_r <= 1'b1;
    end else begin
      hold_empty_r   <= hold_empty_nxt; // RQ18
      tx_empty_r     <= tx_empty_nxt;   // RQ18
      fifo_empty_d_r <= tx_fifo_empty;
    end
  end

  // pass the written byte on to the holding stage or FIFO
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_load_r      <= 1'b0;
      hold_load_data_r <= 8'h00;
    end else begin
      hold_load_r <= tx_wr;
      if (tx_wr) hold_load_data_r <= reg_wdata;
    end
  end

  // ---- receive side ----

  // non-FIFO operation has a single holding slot
  assign rx_cap  = fifo_en ? CW'(RX_DEPTH) : CW'(1);
  assign rx_full = (lnk.count >= rx_cap);

  // characters framed during a break are the break itself
  assign char_in   = rx_char_done && !lnk.brk_event && !lnk.brk_active; // RQ12
  assign want_push = char_in || lnk.brk_event;
  // full store keeps its contents; the new character is lost
  assign do_push     = want_push && !rx_full;  // RQ16
  assign overrun_set = want_push && rx_full;   // RQ16

  // break entry carries only the break tag
  always_comb begin
    new_tags = '0;
    if (lnk.brk_event) begin
      new_tags[uls_pkg::TAG_BRK] = 1'b1; // RQ12
    end else begin
      new_tags[uls_pkg::TAG_PE] = rx_parity_err;  // RQ15
      new_tags[uls_pkg::TAG_FE] = rx_framing_err; // RQ14
    end
  end

  assign lnk.push      = do_push;
  assign lnk.push_tags = new_tags;
  assign lnk.pop       = rx_pop && (lnk.count != '0);
  assign err_push      = do_push && |new_tags;
  assign data_ready    = (lnk.count != '0); // RQ17

  // overrun is sticky until a flag read; a new one wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overrun_r <= 1'b0;
    end else begin
      overrun_r <= overrun_set || (overrun_r && !flags_rd); // RQ16
    end
  end

  // summary falls on a flag read or when no tagged char remains
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_sum_r <= 1'b0; // RQ13
    end else begin
      err_sum_r <= err_push || (err_sum_r && !flags_rd && lnk.err_any); // RQ1 RQ2
    end
  end

  // tell the data path what was accepted
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_store_r       <= 1'b0;
      rx_store_break_r <= 1'b0;
    end else begin
      rx_store_r       <= do_push;
      rx_store_break_r <= do_push && lnk.brk_event;
    end
  end

  // tag store shadowing the receive FIFO
  uls_rx_tags #(
    .DEPTH (RX_DEPTH),
    .CW    (CW)
  ) u_tags (
    .clk (core_clk),
    .rst (rst),
    .tif (lnk)
  );

  // break detector on the receive line
  uls_break_det u_brk (
    .clk          (core_clk),
    .rst          (rst),
    .rx_serial_in (rx_serial_in),
    .rx_bit_tick  (rx_bit_tick),
    .frame_bits   (frame_bits),
    .bif          (lnk)
  );

  // ---- flags and read path ----

  // error bits follow the oldest character and are zero when idle
  always_comb begin
    flags = 8'h00; // RQ13
    flags[uls_pkg::LF_DATA_READY] = data_ready;
    flags[uls_pkg::LF_OVERRUN]    = overrun_r;
    flags[uls_pkg::LF_PARITY]     = lnk.top_tags[uls_pkg::TAG_PE];  // RQ15
    flags[uls_pkg::LF_FRAMING]    = lnk.top_tags[uls_pkg::TAG_FE];  // RQ14
    flags[uls_pkg::LF_BREAK]      = lnk.top_tags[uls_pkg::TAG_BRK]; // RQ11
    flags[uls_pkg::LF_HOLD_EMPTY] = hold_empty_r;
    flags[uls_pkg::LF_TX_EMPTY]   = tx_empty_r;
    flags[uls_pkg::LF_ERR_SUM]    = err_sum_r; // RQ1
  end

  // read mux; data shows for one cycle, zero otherwise
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        uls_pkg::OFS_LINE_FLAGS: rdata_nxt = flags;
        uls_pkg::OFS_CONTROL:    rdata_nxt = ctl_r;
        uls_pkg::OFS_EVT_STATUS: rdata_nxt = {4'h0, evt_r};
        uls_pkg::OFS_EVT_MASK:   rdata_nxt = {4'h0, mask_r};
        default:                 rdata_nxt = 8'h00; // unmapped and write-only
      endcase
    end
  end

  // read data register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---- interrupts ----

  // event sources: rising holding empty, break, overrun, tagged char
  always_comb begin
    evt_set = '0;
    evt_set[uls_pkg::EVT_HOLD]    = hold_empty_nxt && !hold_empty_r;
    evt_set[uls_pkg::EVT_BREAK]   = lnk.brk_event;
    evt_set[uls_pkg::EVT_OVERRUN] = overrun_set;
    evt_set[uls_pkg::EVT_RX_ERR]  = err_push;
  end

  // write one to clear; a same-cycle event survives
  always_comb begin
    evt_nxt = evt_r;
    if (evt_wr) evt_nxt = evt_r & ~reg_wdata[uls_pkg::EVT_W-1:0];
    evt_nxt = evt_nxt | evt_set;
  end

  // mask takes effect in the same edge as the status
  always_comb begin
    mask_nxt = mask_r;
    if (mask_wr) mask_nxt = reg_wdata[uls_pkg::EVT_W-1:0];
  end

  // status and mask registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      evt_r  <= uls_pkg::EVT_RESET;
      mask_r <= uls_pkg::EVT_RESET;
    end else begin
      evt_r  <= evt_nxt;
      mask_r <= mask_nxt;
    end
  end

  // interrupt outputs from flops, computed from next state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_empty_irq_r <= 1'b0;
      irq_r            <= 1'b0;
    end else begin
      hold_empty_irq_r <= hold_empty_nxt && (ctl_wr ? reg_wdata[uls_pkg::CTL_HOLD_IE]
                                                    : hold_ie); // RQ8
      irq_r            <= |(evt_nxt & mask_nxt);
    end
  end

  // outputs straight from flops
  assign reg_rdata      = rdata_r;
  assign hold_load      = hold_load_r;
  assign hold_load_data = hold_load_data_r;
  assign rx_store       = rx_store_r;
  assign rx_store_break = rx_store_break_r;
  assign hold_empty_irq = hold_empty_irq_r;
  assign irq            = irq_r;
endmodule : uls_top
`default_nettype wire

// *** bench/uls_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the line status logic
module uls_checker (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // transmit load and receive store
  input wire logic       hold_load,
  input wire logic [7:0] hold_load_data,
  input wire logic       rx_serial_in,
  input wire logic       rx_store,
  input wire logic       rx_store_break
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // decoded strobes
  wire logic tx_wr = reg_wr && reg_addr == uls_pkg::OFS_TX_DATA;
  wire logic lf_rd = reg_rd && reg_addr == uls_pkg::OFS_LINE_FLAGS;
  load_pulse_a: assert property (tx_wr |=> hold_load && hold_load_data == $past(reg_wdata))
    else $error("transmit write not loaded");
  load_cause_a: assert property (hold_load |-> $past(tx_wr))
    else $error("load without transmit write");
  tx_busy_flags_a: assert property (tx_wr ##1 lf_rd |=> reg_rdata[6:5] == 2'b00)
    else $error("transmit flags not dropped on write");
  tx_empty_hold_a: assert property (lf_rd |=> !reg_rdata[6] || reg_rdata[5])
    else $error("transmit empty without holding empty");
  // read-clear holds unless a new entry lands in between
  errsum_clear_a: assert property ((lf_rd && !rx_store) ##1 !rx_store ##1 (lf_rd && !rx_store)
    |=> !reg_rdata[7])
    else $error("error summary survived a flags read");
  brk_store_a: assert property (rx_store_break |-> rx_store)
    else $error("break marker without store");
  brk_once_a: assert property (rx_store_break |=> !rx_store_break[*2])
    else $error("break stored twice");
  brk_low_a: assert property (rx_store_break |-> !$past(rx_serial_in, 2))
    else $error("break stored with line high");
  cover property (tx_wr ##1 lf_rd);
  cover property (rx_store_break);
  cover property (lf_rd ##1 reg_rdata[7]);
endmodule : uls_checker
bind uls_top uls_checker u_chk (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .hold_load, .hold_load_data, .rx_serial_in, .rx_store, .rx_store_break);
`default_nettype wire

// *** bench/uls_tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// transmit path beside the block: holding stage or FIFO plus shifter
module uls_tx_model #(
  parameter int SH = 6
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // bench holds characters back to act slowly
  input  wire logic stall,
  // load from the block and status back
  input  wire logic hold_load,
  output var logic  tx_to_shifter,
  output logic      tx_shifter_busy,
  output logic      tx_fifo_empty
);
  logic [5:0] q_r;  // characters waiting
  logic [3:0] sh_r; // shifter cycles left
  // move one character when the shifter is free
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_r <= 6'h00;
      sh_r <= 4'h0;
      tx_to_shifter <= 1'b0;
    end else if (!stall && q_r != 6'h00 && sh_r == 4'h0) begin
      tx_to_shifter <= 1'b1;
      sh_r <= 4'(SH);
      q_r <= q_r - 6'h01 + {5'h00, hold_load};
    end else begin
      tx_to_shifter <= 1'b0;
      q_r <= q_r + {5'h00, hold_load};
      if (sh_r != 4'h0) sh_r <= sh_r - 4'h1;
    end
  end
  assign tx_shifter_busy = sh_r != 4'h0;
  assign tx_fifo_empty   = q_r == 6'h00;
endmodule : uls_tx_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] TX = uls_pkg::OFS_TX_DATA;
  localparam logic [3:0] LF = uls_pkg::OFS_LINE_FLAGS;
  localparam logic [3:0] CT = uls_pkg::OFS_CONTROL;
  localparam logic [3:0] ST = uls_pkg::OFS_EVT_STATUS;
  localparam logic [3:0] MK = uls_pkg::OFS_EVT_MASK;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stall = 0;
  logic [3:0] reg_addr = 0, frame_bits = 4'ha;
  logic [7:0] reg_wdata = 0, reg_rdata, hold_load_data, d, brk_n = 0;
  logic tx_to_shifter, tx_shifter_busy, tx_fifo_empty, hold_load, rx_store, rx_store_break;
  logic rx_char_done = 0, rx_parity_err = 0, rx_framing_err = 0, rx_pop = 0;
  logic rx_serial_in = 1, rx_bit_tick = 0, hold_empty_irq, irq;
  int err_total = 0, n_tests = 0;
  always #2 core_clk = ~core_clk;
  // break entries seen on the store side
  always @(posedge core_clk) if (rx_store_break) brk_n <= brk_n + 8'h01;
  uls_top u_dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .tx_to_shifter, .tx_shifter_busy, .tx_fifo_empty, .hold_load, .hold_load_data,
    .rx_char_done, .rx_parity_err, .rx_framing_err, .rx_pop, .rx_serial_in, .rx_bit_tick,
    .frame_bits, .rx_store, .rx_store_break, .hold_empty_irq, .irq);
  uls_tx_model u_tx (.core_clk, .rst, .stall, .hold_load, .tx_to_shifter, .tx_shifter_busy,
    .tx_fifo_empty);
  task automatic summarize;
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands in the cycle after the strobe only
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  // write, then a flags read in the very next cycle, no gap
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= LF;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : wr_rd
  task automatic pulse_rx(input logic pe, input logic fe, input logic pop);
    @(posedge core_clk);
    rx_char_done <= !pop; rx_parity_err <= pe; rx_framing_err <= fe; rx_pop <= pop;
    @(posedge core_clk);
    rx_char_done <= 1'b0; rx_pop <= 1'b0;
  endtask : pulse_rx
  // bounded poll until the transmit path drains
  task automatic wait_txe;
    for (int i = 0; i < 40; i++) begin
      rd(LF);
      if (d[6]) return;
    end
    err_total++;
    $display("[ERR] %0t transmit never drained", $time);
    summarize;
  endtask : wait_txe
  task automatic t_reset;
    rd(LF); chk(d, 8'h60);
    rd(CT); chk(d, 8'h00);
    rd(4'hf); chk(d, 8'h00);
  endtask : t_reset
  task automatic t_tx;
    stall <= 1'b1;
    wr_rd(TX, 8'ha5);
    chk(d & 8'h60, 8'h00);
    stall <= 1'b0;
    wait_txe;
    chk(d, 8'h60);
    rd(LF); chk(d, 8'h60);
  endtask : t_tx
  task automatic t_irq;
    wr(ST, 8'h0f); wr(MK, 8'h01); wr(CT, 8'h02);
    repeat (2) @(posedge core_clk);
    #1 chk({6'h00, hold_empty_irq, irq}, 8'h02);
    stall <= 1'b1;
    wr(TX, 8'h3c);
    repeat (2) @(posedge core_clk);
    #1 chk({6'h00, hold_empty_irq, irq}, 8'h00);
    stall <= 1'b0;
    wait_txe;
    chk({6'h00, hold_empty_irq, irq}, 8'h03);
    wr(MK, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 chk({6'h00, hold_empty_irq, irq}, 8'h02);
    rd(ST); chk(d, 8'h01);
    wr(ST, 8'h01); rd(ST); chk(d, 8'h00);
  endtask : t_irq
  task automatic t_fifo;
    wr(CT, 8'h01);
    stall <= 1'b1;
    wr(TX, 8'h11); wr_rd(TX, 8'h22);
    chk(d & 8'h60, 8'h00);
    stall <= 1'b0;
    wait_txe;
    chk(d, 8'h60);
  endtask : t_fifo
  task automatic t_rx;
    pulse_rx(1'b1, 1'b0, 1'b0); pulse_rx(1'b0, 1'b1, 1'b0);
    rd(LF); chk(d, 8'he5);
    rd(LF); chk(d, 8'h65);
    pulse_rx(1'b0, 1'b0, 1'b1);
    rd(LF); chk(d, 8'h69);
    pulse_rx(1'b0, 1'b0, 1'b1);
    rd(LF); chk(d, 8'h60);
  endtask : t_rx
  task automatic t_ovr;
    wr(CT, 8'h00);
    pulse_rx(1'b0, 1'b0, 1'b0); pulse_rx(1'b0, 1'b0, 1'b0);
    rd(LF); chk(d, 8'h63);
    rd(LF); chk(d, 8'h61);
    // hold rise, tagged stores and the overrun are all pending
    rd(ST); chk(d, 8'h0d);
    pulse_rx(1'b0, 1'b0, 1'b1);
  endtask : t_ovr
  task automatic t_brk;
    wr(ST, 8'h0f);
    wr(CT, 8'h01);
    rx_serial_in <= 1'b0;
    repeat (30) begin
      @(posedge core_clk) rx_bit_tick <= 1'b1;
      @(posedge core_clk) rx_bit_tick <= 1'b0;
    end
    rd(LF); chk(d, 8'hf1);
    chk(brk_n, 8'h01);
    // break event and its tagged entry, nothing else
    rd(ST); chk(d, 8'h0a);
    @(posedge core_clk);
    rx_serial_in <= 1'b1;
    pulse_rx(1'b0, 1'b0, 1'b1);
    rd(LF); chk(d, 8'h60);
  endtask : t_brk
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_reset; t_tx; t_irq; t_fifo; t_rx; t_ovr; t_brk;
    summarize;
  end
endmodule : tb_top
`default_nettype wire
